/* src/cylinder_difference.sv */
// Bit-serial cylinder difference unit: two ring shifts of the current
// and desired cylinder registers leave the difference in the current one.
// Assumes one shift_en pulse per bit-time from the parent sequencer.
`timescale 1ns/10ps
`include "disk_seek_consts.svh"

module cylinder_difference
  import disk_seek_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              load,
  input  wire logic [`CYL_W-1:0] cur_in,
  input  wire logic [`CYL_W-1:0] des_in,
  input  wire logic              arm,
  input  wire logic              shift_en,
  input  wire logic              pass_two,
  input  wire logic              last_bit,
  output logic      [`CYL_W-1:0] current_cylinder_q,
  output logic      [`CYL_W-1:0] desired_cylinder_q,
  output logic                   cylinder_equal_flag_q,
  output logic                   increment_flag_q,
  output logic                   complement_flag_q
);

  logic previous_carry_flag_q;  // Carry held from the last stage
  logic current_carry_gate;     // Carry out of the stage now shifting
  logic sum_gate;               // Bit written back into the current register
  logic c0;                     // Bit leaving the current register
  logic d0;                     // Bit leaving the desired register

  // Stage logic: adds inverted current to desired, or corrects it
  always_comb begin
    c0 = current_cylinder_q[0];
    d0 = desired_cylinder_q[0];
    if (!pass_two) begin
      sum_gate           = d0 ^ ~c0 ^ previous_carry_flag_q;
      current_carry_gate = (d0 & ~c0) | (previous_carry_flag_q & (d0 | ~c0));
    end else if (increment_flag_q) begin
      // Invert while a carry is still rippling, pass true after it
      sum_gate           = c0 ^ previous_carry_flag_q;
      current_carry_gate = c0 & previous_carry_flag_q;
    end else begin
      // Equal or backward case: plain one's complement
      sum_gate           = ~c0;
      current_carry_gate = 1'b0;
    end
  end

  // Both registers ring-shift LSB first, one bit per bit-time
  always_ff @(posedge clk) begin
    if (rst) begin
      current_cylinder_q <= '0;
      desired_cylinder_q <= '0;
    end else if (load) begin
      current_cylinder_q <= cur_in;
      desired_cylinder_q <= des_in;
    end else if (shift_en) begin
      current_cylinder_q <= {sum_gate, current_cylinder_q[`CYL_W-1:1]};
      desired_cylinder_q <= {d0, desired_cylinder_q[`CYL_W-1:1]};
    end
  end

  // Carry chain: pass one's final carry seeds the increment pass
  always_ff @(posedge clk) begin
    if (rst || arm) begin
      previous_carry_flag_q <= 1'b0;
    end else if (shift_en) begin
      previous_carry_flag_q <= current_carry_gate;
    end
  end

  // Direction flags: equal set at arm, cleared by any false pass-one sum bit
  always_ff @(posedge clk) begin
    if (rst) begin
      cylinder_equal_flag_q <= 1'b0;
      increment_flag_q      <= 1'b0;
      complement_flag_q     <= 1'b0;
    end else if (arm) begin
      cylinder_equal_flag_q <= 1'b1;
      increment_flag_q      <= 1'b0;
      complement_flag_q     <= 1'b0;
    end else if (shift_en && !pass_two) begin
      if (!sum_gate) begin
        cylinder_equal_flag_q <= 1'b0;
      end
      if (last_bit && current_carry_gate) begin
        increment_flag_q <= 1'b1;
      end else if (last_bit && !(cylinder_equal_flag_q && sum_gate)) begin
        complement_flag_q <= 1'b1;
      end
    end
  end

endmodule : cylinder_difference

/* src/disk_out_seek_setup.sv */
// Sequence state four of a disk output command: fetch of the start
// address word, serial load of the block/word count, cylinder difference
// and the difference strobe to the disk. Registers sit behind APB.
// Assumes the coupler's ready and data pins are asynchronous to clk.
//
// Function
// - Start-address word goes buffer, then core address
// - Request word; clear buffer before loading
// - Count word shift starts at first L23 CK2
// - Collection register fills with zeroes
// - Bits 00-13 enter count during L00-L13
// - Clear six low count bits at L18
// - Count is whole sixty-four word blocks
// - Add inverted current to desired, then correct
// - False sum bit clears equal flag
// - Equal case complements all-ones to zero
// - Final carry sets increment flag, adds one
// - No carry and unequal: complement current register
// - Increment forward, complement reverse, equal neither
// - Increment pass inverts bits while carry
// - Unequal: strobe difference during L18, L19
// - Gray counter advances after starting L23
// - Equal flag blocks the difference strobe
// - Transfer pulse end loads address, enters five
// - Count two is the difference send window
// - Current cylinder holds value read earlier
`timescale 1ns/10ps
`include "disk_seek_consts.svh"

module disk_out_seek_setup
  import disk_seek_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire apb_req_s          apb_req,
  output apb_rsp_s               apb_rsp,
  input  wire logic              mem_ready,
  input  wire logic [`WORD_W-1:0] mem_data,
  output logic                   memory_request_flag,
  output logic                   transfer_pulse,
  output logic                   difference_select_strobe,
  output logic      [`CYL_W-1:0] difference_bus,
  output logic                   seek_forward_driver,
  output logic                   seek_reverse_driver
);

  // Sequencer state
  seq_state_e           state_q;            // Current sequence state
  logic [1:0]           phase_q;            // Clock phase within a bit-time
  logic [4:0]           lcnt_q;             // L bit-time number
  logic                 first_l23_q;        // Inside the L23 that opens the state
  logic                 in_frame_q;         // Inside the L00..L23 frame of the state
  logic [1:0]           gray_q;             // Gray-code position counter
  logic                 transfer_done_q;    // Trailing edge of transfer pulse

  // Data path registers
  logic [`WORD_W-1:0]   data_buffer_reg_q;      // Word from memory
  logic [`WORD_W-1:0]   core_address_reg_q;     // Start address for transfers
  logic [`WORD_W-1:0]   serial_collection_reg_q; // Holds the count word
  logic                 retime_flop_q;          // Serial bit retimed
  logic [`COUNT_W-1:0]  block_word_count_q;     // Block/word count
  logic                 buffer_loaded_q;        // Buffer holds the address word
  logic                 load_pending_q;         // Buffer cleared, load next

  // Software-held cylinder inputs
  logic [`CYL_W-1:0]    cur_cyl_sw_q;       // Current cylinder as read from disk
  logic [`CYL_W-1:0]    des_cyl_sw_q;       // Desired cylinder
  logic                 cyl_load_q;         // One-cycle load into the unit

  // Pin synchronisers: first stage feeds only the second
  logic                 rdy_s1_q;
  logic                 rdy_s2_q;
  logic                 rdy_s3_q;
  logic [`WORD_W-1:0]   data_s1_q;
  logic [`WORD_W-1:0]   data_s2_q;

  // Cylinder unit outputs
  logic [`CYL_W-1:0]    current_cylinder;
  logic [`CYL_W-1:0]    desired_cylinder;
  logic                 cylinder_equal_flag;
  logic                 increment_flag;
  logic                 complement_flag;

  // Decoded timing
  logic ck1;          // First phase of a bit-time
  logic ck2;          // Second sampling phase
  logic bit_end;      // Last clock of a bit-time
  logic in_ss4;       // Sequence state four active
  logic start_req;    // Software start accepted
  logic cyl_shift;    // Cylinder unit shifts this cycle
  logic ready_rise;   // Memory word became ready
  logic access;       // APB access phase
  logic do_write;     // Write takes effect now
  logic busy;         // State four running

  // True when the address hits one of the mapped registers
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      `REG_CTRL, `REG_CYL, `REG_COUNT_WORD,
      `REG_STATUS, `REG_CORE_ADDR, `REG_BUFFER: is_mapped = 1'b1;
      default:                                  is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Phase and bus decodes
  always_comb begin
    ck1        = (phase_q == `PH_CK1);
    ck2        = (phase_q == `PH_CK2);
    bit_end    = (phase_q == `PH_LAST);
    in_ss4     = (state_q == st_ss4);
    busy       = in_ss4;
    access     = apb_req.psel && apb_req.penable;
    do_write   = access && apb_rsp.pready && apb_req.pwrite &&
                 is_mapped(apb_req.paddr);
    start_req  = do_write && (apb_req.paddr == `REG_CTRL) &&
                 apb_req.pwdata[`CTRL_START_BIT] && !busy;
    cyl_shift  = in_ss4 && in_frame_q && ck2 && (lcnt_q <= `L_P2_LAST);
    ready_rise = rdy_s2_q && !rdy_s3_q;
  end

  // Two-flop synchronisers for the coupler's ready and data lines
  always_ff @(posedge clk) begin
    if (rst) begin
      rdy_s1_q  <= 1'b0;
      rdy_s2_q  <= 1'b0;
      rdy_s3_q  <= 1'b0;
      data_s1_q <= '0;
      data_s2_q <= '0;
    end else begin
      rdy_s1_q  <= mem_ready;
      rdy_s2_q  <= rdy_s1_q;
      rdy_s3_q  <= rdy_s2_q;
      data_s1_q <= mem_data;
      data_s2_q <= data_s1_q;
    end
  end

  // Bit-time generator; runs only while state four is active
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 2'd0;
      lcnt_q  <= `L_LAST;
    end else if (start_req) begin
      // State four opens at the CK1 of an L23
      phase_q <= 2'd0;
      lcnt_q  <= `L_LAST;
    end else if (in_ss4) begin
      phase_q <= bit_end ? 2'd0 : phase_q + 2'd1;
      if (bit_end) begin
        lcnt_q <= (lcnt_q == `L_LAST) ? `L_FIRST : lcnt_q + 5'd1;
      end
    end
  end

  // Frame markers and the gray-code position counter
  always_ff @(posedge clk) begin
    if (rst) begin
      first_l23_q <= 1'b0;
      in_frame_q  <= 1'b0;
      gray_q      <= 2'b00;
    end else if (start_req) begin
      first_l23_q <= 1'b1;
      in_frame_q  <= 1'b0;
      gray_q      <= `GRAY_COUNT_ONE;
    end else if (in_ss4 && bit_end && lcnt_q == `L_LAST) begin
      if (first_l23_q) begin
        // Trailing edge of the opening L23
        first_l23_q <= 1'b0;
        in_frame_q  <= 1'b1;
        gray_q      <= `GRAY_COUNT_TWO;
      end else begin
        // Later frames only wait for the address word
        in_frame_q  <= 1'b0;
      end
    end
  end

  // Sequence state counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= st_idle;
    end else if (start_req) begin
      state_q <= st_ss4;
    end else if (transfer_done_q) begin
      state_q <= st_ss5;
    end
  end

  // Memory request for the start-address word
  always_ff @(posedge clk) begin
    if (rst) begin
      memory_request_flag <= 1'b0;
    end else if (start_req) begin
      memory_request_flag <= 1'b1;
    end else if (ready_rise && memory_request_flag) begin
      memory_request_flag <= 1'b0;
    end
  end

  // Buffer: cleared when the word turns ready, loaded one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      data_buffer_reg_q <= '0;
      load_pending_q    <= 1'b0;
      buffer_loaded_q   <= 1'b0;
    end else if (start_req) begin
      load_pending_q    <= 1'b0;
      buffer_loaded_q   <= 1'b0;
    end else if (ready_rise && memory_request_flag) begin
      data_buffer_reg_q <= '0;
      load_pending_q    <= 1'b1;
    end else if (load_pending_q) begin
      data_buffer_reg_q <= data_s2_q;
      load_pending_q    <= 1'b0;
      buffer_loaded_q   <= 1'b1;
    end
  end

  // Transfer pulse in the cycle after CK1 of the first later L23 with the buffer loaded; its trailing edge moves
  // the word into the core address register
  always_ff @(posedge clk) begin
    if (rst) begin
      transfer_pulse     <= 1'b0;
      transfer_done_q    <= 1'b0;
      core_address_reg_q <= '0;
    end else begin
      transfer_pulse  <= in_ss4 && !first_l23_q && ck1 &&
                         (lcnt_q == `L_LAST) && buffer_loaded_q &&
                         !transfer_pulse && !transfer_done_q;
      transfer_done_q <= transfer_pulse;
      if (transfer_pulse) begin
        core_address_reg_q <= data_buffer_reg_q;
      end
    end
  end

  // Collection register shifts out LSB first from the opening L23 CK2
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_collection_reg_q <= '0;
      retime_flop_q           <= 1'b0;
    end else if (do_write && !busy && apb_req.paddr == `REG_COUNT_WORD) begin
      serial_collection_reg_q <= apb_req.pwdata[`WORD_W-1:0];
    end else if (in_ss4 && ck2) begin
      retime_flop_q           <= serial_collection_reg_q[0];
      serial_collection_reg_q <= {1'b0, serial_collection_reg_q[`WORD_W-1:1]};
    end
  end

  // Block/word count: serial load, then trimmed to whole blocks
  always_ff @(posedge clk) begin
    if (rst) begin
      block_word_count_q <= '0;
    end else if (in_ss4 && in_frame_q && ck2 && lcnt_q <= `L_COUNT_LAST) begin
      block_word_count_q <= {retime_flop_q, block_word_count_q[`COUNT_W-1:1]};
    end else if (in_ss4 && in_frame_q && ck1 && lcnt_q == `L_CLEAR_LOW) begin
      block_word_count_q[`LOW_CLEAR_W-1:0] <= '0;
    end
  end

  // Cylinder values written by software while idle
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_cyl_sw_q <= '0;
      des_cyl_sw_q <= '0;
      cyl_load_q   <= 1'b0;
    end else begin
      cyl_load_q <= do_write && !busy && (apb_req.paddr == `REG_CYL);
      if (do_write && !busy && apb_req.paddr == `REG_CYL) begin
        des_cyl_sw_q <= apb_req.pwdata[`CYL_DES_LSB +: `CYL_W];
        cur_cyl_sw_q <= apb_req.pwdata[`CYL_CUR_LSB +: `CYL_W];
      end
    end
  end

  // Two-pass serial subtraction
  cylinder_difference u_diff (
    .clk                   (clk),
    .rst                   (rst),
    .load                  (cyl_load_q),
    .cur_in                (cur_cyl_sw_q),
    .des_in                (des_cyl_sw_q),
    .arm                   (start_req),
    .shift_en              (cyl_shift),
    .pass_two              (lcnt_q >= `L_P2_FIRST),
    .last_bit              (lcnt_q == `L_P1_LAST),
    .current_cylinder_q    (current_cylinder),
    .desired_cylinder_q    (desired_cylinder),
    .cylinder_equal_flag_q (cylinder_equal_flag),
    .increment_flag_q      (increment_flag),
    .complement_flag_q     (complement_flag)
  );

  // Difference strobe in count two, L18-L19, unless equal
  always_ff @(posedge clk) begin
    if (rst) begin
      difference_select_strobe <= 1'b0;
      difference_bus           <= '0;
    end else begin
      difference_select_strobe <= in_ss4 && in_frame_q &&
                                  (gray_q == `GRAY_COUNT_TWO) &&
                                  !cylinder_equal_flag &&
                                  (lcnt_q == `L_STROBE_A || lcnt_q == `L_STROBE_B);
      difference_bus <= (in_ss4 && in_frame_q && gray_q == `GRAY_COUNT_TWO &&
                         !cylinder_equal_flag) ? current_cylinder : '0;
    end
  end

  // Seek direction drivers; both quiet when the cylinders match
  always_ff @(posedge clk) begin
    if (rst) begin
      seek_forward_driver <= 1'b0;
      seek_reverse_driver <= 1'b0;
    end else begin
      seek_forward_driver <= increment_flag && !cylinder_equal_flag;
      seek_reverse_driver <= complement_flag && !cylinder_equal_flag;
    end
  end

  // APB slave: one wait state, read data and error set with pready
  always_ff @(posedge clk) begin
    if (rst) begin
      apb_rsp <= '0;
    end else if (access && !apb_rsp.pready) begin
      apb_rsp.pready  <= 1'b1;
      apb_rsp.pslverr <= !is_mapped(apb_req.paddr);
      apb_rsp.prdata  <= '0;
      if (!apb_req.pwrite) begin
        case (apb_req.paddr)
          `REG_CYL: begin
            apb_rsp.prdata <= {16'h0000, current_cylinder, desired_cylinder};
          end
          `REG_COUNT_WORD: begin
            apb_rsp.prdata <= {8'h00, serial_collection_reg_q};
          end
          `REG_STATUS: begin
            apb_rsp.prdata <= {2'b00, block_word_count_q, 8'h00,
                               seek_reverse_driver, seek_forward_driver,
                               memory_request_flag, complement_flag,
                               increment_flag, cylinder_equal_flag,
                               (state_q == st_ss5), busy};
          end
          `REG_CORE_ADDR: begin
            apb_rsp.prdata <= {8'h00, core_address_reg_q};
          end
          `REG_BUFFER: begin
            apb_rsp.prdata <= {8'h00, data_buffer_reg_q};
          end
          default: begin
            apb_rsp.prdata <= '0;
          end
        endcase
      end
    end else begin
      // Answer lasts exactly one cycle
      apb_rsp.pready  <= 1'b0;
      apb_rsp.pslverr <= 1'b0;
    end
  end

endmodule : disk_out_seek_setup

/* src/disk_seek_consts.svh */
// Constants for the state-four seek setup block: register offsets,
// field positions, bit-time figures and register widths.
// Assumes inclusion by bare name from both design files.
`ifndef DISK_SEEK_CONSTS_SVH
`define DISK_SEEK_CONSTS_SVH

// Register offsets (byte addresses on the 8-bit APB address)
`define REG_CTRL        8'h00
`define REG_CYL         8'h04
`define REG_COUNT_WORD  8'h08
`define REG_STATUS      8'h0c
`define REG_CORE_ADDR   8'h10
`define REG_BUFFER      8'h14

// Field positions
`define CTRL_START_BIT  0
`define CYL_DES_LSB     0
`define CYL_CUR_LSB     8
`define ST_BUSY_BIT     0
`define ST_SS5_BIT      1
`define ST_EQUAL_BIT    2
`define ST_INC_BIT      3
`define ST_CMP_BIT      4
`define ST_MREQ_BIT     5
`define ST_FWD_BIT      6
`define ST_REV_BIT      7
`define ST_COUNT_LSB    16

// Widths
`define WORD_W          24
`define COUNT_W         14
`define CYL_W           8
`define LOW_CLEAR_W     6

// Timing: one L bit-time is a fixed number of clock cycles
`define CLK_PERIOD_NS   100
`define BIT_TIME_NS     400
`define BIT_CYCLES      (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define PH_CK1          2'd0
`define PH_CK2          2'd2
`define PH_LAST         2'(`BIT_CYCLES - 1)

// L bit-time numbers
`define L_FIRST         5'd0
`define L_COUNT_LAST    5'd13
`define L_P1_LAST       5'd7
`define L_P2_FIRST      5'd8
`define L_P2_LAST       5'd15
`define L_CLEAR_LOW     5'd18
`define L_STROBE_A      5'd18
`define L_STROBE_B      5'd19
`define L_LAST          5'd23

// Gray-code position counter values
`define GRAY_COUNT_ONE  2'b01
`define GRAY_COUNT_TWO  2'b11

`endif

/* src/disk_seek_pkg.sv */
// Types shared by the seek setup block: sequence states and the
// APB request and response bundles.
// Assumes nothing beyond a SystemVerilog compiler.
package disk_seek_pkg;

  // Sequence states seen by this block
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_ss4  = 2'b01,
    st_ss5  = 2'b10
  } seq_state_e;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage : disk_seek_pkg

/* test/coupler_model.sv */
// Memory coupler model: answers each memory request with one word.
// Assumes the request level stays up until the ready is seen.
`timescale 1ns/10ps

module coupler_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        memory_request_flag,
  input  wire logic [7:0]  delay,
  input  wire logic [23:0] word,
  output logic             mem_ready,
  output logic [23:0]      mem_data
);
  logic [7:0] wait_q;      // Cycles spent before answering

  // Answer after a chosen delay; idle data is the inverse, not a stale copy
  always @(posedge clk) begin
    if (rst) begin
      mem_ready <= 1'b0;
      mem_data  <= '0;
      wait_q    <= '0;
    end else if (memory_request_flag && !mem_ready) begin
      if (wait_q >= delay) begin
        mem_ready <= 1'b1;
        mem_data  <= word;
      end else begin
        wait_q <= wait_q + 8'h01;
      end
    end else if (!memory_request_flag && mem_ready) begin
      // Released: data no longer valid
      mem_ready <= 1'b0;
      mem_data  <= ~mem_data;
      wait_q    <= '0;
    end
  end
endmodule : coupler_model

/* test/disk_seek_props.sv */
// Checker on the seek setup block's ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
`include "disk_seek_consts.svh"

module disk_seek_props
  import disk_seek_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire apb_req_s          apb_req,
  input wire apb_rsp_s          apb_rsp,
  input wire logic              mem_ready,
  input wire logic [`WORD_W-1:0] mem_data,
  input wire logic              memory_request_flag,
  input wire logic              transfer_pulse,
  input wire logic              difference_select_strobe,
  input wire logic [`CYL_W-1:0] difference_bus,
  input wire logic              seek_forward_driver,
  input wire logic              seek_reverse_driver
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held too long");
  err_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  ready_cause_a: assert property ($rose(apb_rsp.pready) |-> $past(apb_req.penable))
    else $error("pready without access phase");
  // Strobe spans exactly two bit-times
  strobe_length_a: assert property ($rose(difference_select_strobe)
    |-> difference_select_strobe[*8] ##1 !difference_select_strobe) else $error("strobe length");
  strobe_unequal_a: assert property (difference_select_strobe
    |-> (seek_forward_driver ^ seek_reverse_driver)) else $error("strobe while equal");
  drivers_apart_a: assert property (!(seek_forward_driver && seek_reverse_driver))
    else $error("both seek drivers on");
  bus_steady_a: assert property (difference_select_strobe && $past(difference_select_strobe)
    |-> $stable(difference_bus)) else $error("difference moved in strobe");
  request_drop_a: assert property ($rose(mem_ready) |-> ##[1:8] !memory_request_flag)
    else $error("request not dropped");
  xfer_once_a: assert property (transfer_pulse
    |-> !memory_request_flag ##1 !transfer_pulse) else $error("transfer pulse wrong");

  strobe_c: cover property ($rose(difference_select_strobe));
  xfer_c:   cover property (transfer_pulse);
  rev_c:    cover property (seek_reverse_driver);
endmodule : disk_seek_props

bind disk_out_seek_setup disk_seek_props u_props (
  .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .mem_ready(mem_ready),
  .mem_data(mem_data), .memory_request_flag(memory_request_flag),
  .transfer_pulse(transfer_pulse), .difference_select_strobe(difference_select_strobe),
  .difference_bus(difference_bus), .seek_forward_driver(seek_forward_driver),
  .seek_reverse_driver(seek_reverse_driver));

/* test/tb_disk_out_seek_setup.sv */
// Testbench: APB sequences run state four for four cylinder cases.
// Assumes the coupler model answers memory requests.
`timescale 1ns/10ps
`include "disk_seek_consts.svh"

module tb_disk_out_seek_setup
  import disk_seek_pkg::*;
();
  logic clk, rst, mem_ready, mrq, xfer, strobe, fwd, rev;
  apb_req_s    req;         // Master request
  apb_rsp_s    rsp;         // Slave answer
  logic [23:0] mem_data, word;
  logic [7:0]  dbus, dly, s_bus;
  logic        s_last = 0;  // Strobe one cycle ago
  int fail_count = 0, num_checks = 0, cyc = 0, t_cyc = 0, s_tot = 0, s_rise = 0;

  disk_out_seek_setup dut (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .mem_ready(mem_ready), .mem_data(mem_data), .memory_request_flag(mrq),
    .transfer_pulse(xfer), .difference_select_strobe(strobe), .difference_bus(dbus),
    .seek_forward_driver(fwd), .seek_reverse_driver(rev));
  coupler_model partner (.clk(clk), .rst(rst), .memory_request_flag(mrq), .delay(dly),
    .word(word), .mem_ready(mem_ready), .mem_data(mem_data));

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // Strobe watcher: length, first cycle and what the bus carried
  always @(posedge clk) begin
    cyc    <= cyc + 1;
    s_last <= strobe;
    if (strobe === 1'b1) begin
      s_tot <= s_tot + 1;
      s_bus <= dbus;
      if (!s_last) s_rise <= cyc;
    end
  end

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      stop_test;
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    t_cyc = cyc;
    req <= '0;
  endtask : apb

  // Whole state-four run with expectations from the subtraction rules
  task run_case(input logic [7:0] cur, des, input logic [23:0] cw, a, input logic [7:0] d);
    logic [31:0] r;
    logic        e, up, dn;
    logic [7:0]  df;
    int          n, s0, ec;
    up = cur < des;
    dn = cur > des;
    df = up ? des - cur : cur - des;
    word <= a;
    dly <= d;
    s0 = s_tot;
    n = 0;
    apb(1'b1, `REG_CYL, {16'h0000, cur, des}, r, e);
    apb(1'b1, `REG_COUNT_WORD, {8'h00, cw}, r, e);
    apb(1'b1, `REG_CTRL, 32'h0000_0001, r, e);
    ec = t_cyc;
    do begin
      apb(1'b0, `REG_STATUS, 32'h0, r, e);
      n++;
    end while (r[1] !== 1'b1 && n < 100);
    if (n >= 100) begin
      fail_count++;
      stop_test;
    end
    chk(r, {2'b00, cw[13:6], 6'h00, 8'h00, dn, up, 1'b0, dn, up, !(up | dn), 2'b10});
    chk({fwd, rev}, {up, dn});
    apb(1'b0, `REG_CYL, 32'h0, r, e);
    chk(r, {16'h0000, df, des});
    apb(1'b0, `REG_CORE_ADDR, 32'h0, r, e);
    chk(r, {8'h00, a});
    apb(1'b0, `REG_BUFFER, 32'h0, r, e);
    chk(r, {8'h00, a});
    apb(1'b0, `REG_COUNT_WORD, 32'h0, r, e);
    chk(r, 32'h0);
    chk(s_tot - s0, (up | dn) ? 8 : 0);
    if (up | dn) begin
      chk(s_bus, df);
      chk((s_rise - ec) inside {[77:79]}, 1);
    end
  endtask : run_case

  initial begin
    logic [31:0] r;
    logic        e;
    req = '0;
    rst = 1'b1;
    dly = 8'h00;
    word = 24'h000000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk(e, 1);
    chk(r, 32'h0);
    run_case(8'h46, 8'h46, 24'hffffff, 24'h000123, 8'h00);
    run_case(8'h10, 8'h2d, 24'h123456, 24'h7ffffe, 8'h1e);
    run_case(8'hc8, 8'h05, 24'h00003f, 24'h0a5a5a, 8'h03);
    // Late word: the transfer pulse has to wait for a later L23
    run_case(8'h00, 8'hff, 24'h000040, 24'hfedcba, 8'h70);
    stop_test;
  end
endmodule : tb_disk_out_seek_setup
